//--- verilog/sepr_top.sv
// Purpose: two-wire slave serving reads of a byte array
// Assumes: SCL and SDA are asynchronous pins sampled by i_mclk
// Notes: byte writes advance the counter and start a write cycle but are not stored in the array
`timescale 1ns/10ps
`default_nettype none
module sepr_top #(
  parameter int WRITE_CYCLE_CYC = sepr_pkg::WRITE_CYCLE_CYC,
  parameter int FIFO_DEPTH = 16
) (
  input wire logic i_mclk,
  input wire logic i_rst_b,
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_sda,
  output logic o_sda_oe_b,
  input wire logic i_device_select_strap_hi,
  input wire logic i_device_select_strap_mid,
  input wire logic i_device_select_strap_lo,
  output logic o_busy
);
  localparam int AW = sepr_pkg::ADDR_W;
  initial begin
    if (WRITE_CYCLE_CYC < 1 || FIFO_DEPTH < 2) begin
      $error("sepr_top: bad parameters");
    end
  end
  // ****************
  // pin synchronisers
  // ****************
  logic [1:0] scl_sync_reg;
  logic [1:0] sda_sync_reg;
  logic scl_d_reg;
  logic sda_d_reg;
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      scl_sync_reg <= 2'h3;
      sda_sync_reg <= 2'h3;
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
    end else begin
      scl_sync_reg <= {scl_sync_reg[0], i_scl};
      sda_sync_reg <= {sda_sync_reg[0], i_sda};
      scl_d_reg <= scl_sync_reg[1];
      sda_d_reg <= sda_sync_reg[1];
    end
  end
  logic scl_s;
  logic sda_s;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  assign scl_s = scl_sync_reg[1];
  assign sda_s = sda_sync_reg[1];
  assign scl_rise = scl_s && !scl_d_reg;
  assign scl_fall = !scl_s && scl_d_reg;
  // sda edges while scl high
  assign start_det = scl_s && scl_d_reg && sda_d_reg && !sda_s;
  assign stop_det = scl_s && scl_d_reg && !sda_d_reg && sda_s;
  // ****************
  // strap capture after reset release
  // ****************
  logic [2:0] strap_meta_reg;
  logic [2:0] strap_reg;
  // straps are pins: two flops before the match logic reads them
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      strap_meta_reg <= 3'h0;
      strap_reg <= 3'h0;
    end else begin
      strap_meta_reg <= {i_device_select_strap_hi, i_device_select_strap_mid,
                         i_device_select_strap_lo};
      strap_reg <= strap_meta_reg;
    end
  end
  // address byte match test
  function automatic logic addr_match(input logic [7:0] b, input logic [2:0] s);
    addr_match = (b[7:4] == sepr_pkg::SLAVE_PATTERN) && (b[3:1] == s);
  endfunction
  // ****************
  // bit framing
  // ****************
  sepr_pkg::sepr_state_t state_reg;
  logic [3:0] bit_reg;
  logic [7:0] shift_reg;
  logic [7:0] rx_byte;
  logic byte_done;
  logic ack_slot;
  logic drive_ack_reg;
  logic drive_data_reg;
  logic [7:0] tx_reg;
  logic master_not_acknowledge_reg;
  logic ack_high_reg;
  logic ack_open;
  logic ack_close;
  logic ack_due;
  assign rx_byte = {shift_reg[6:0], sda_s};
  assign byte_done = scl_rise && (bit_reg == sepr_pkg::BIT_LAST);
  assign ack_slot = bit_reg == sepr_pkg::BIT_ACK;
  // ninth clock opens on the fall after the eighth bit, closes on the next fall
  assign ack_open = scl_fall && ack_slot && !ack_high_reg;
  assign ack_close = scl_fall && ack_slot && ack_high_reg;
  // device acks address match, address bytes and written data, never read data
  assign ack_due = (state_reg == sepr_pkg::ST_ADDR_HI) || (state_reg == sepr_pkg::ST_ADDR_LO)
                   || (state_reg == sepr_pkg::ST_WDATA)
                   || (state_reg == sepr_pkg::ST_RDATA && !drive_data_reg);
  // bit counter and receive shifter, data taken on rising scl
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      bit_reg <= 4'h0;
      shift_reg <= 8'h00;
      ack_high_reg <= 1'b0;
    end else if (start_det) begin
      bit_reg <= 4'h0;
      ack_high_reg <= 1'b0;
    end else if (ack_close) begin
      bit_reg <= 4'h0;
      ack_high_reg <= 1'b0;
    end else if (scl_rise && ack_slot) begin
      ack_high_reg <= 1'b1;
    end else if (scl_rise && !ack_slot) begin
      shift_reg <= rx_byte;
      bit_reg <= bit_reg + 4'h1;
    end
  end
  // ****************
  // write cycle timer
  // ****************
  logic [$clog2(WRITE_CYCLE_CYC+1)-1:0] wcyc_reg;
  logic wr_pending_reg;
  assign o_busy = wcyc_reg != '0;
  // ****************
  // address counter and stream
  // ****************
  logic [AW-1:0] cnt_reg;
  logic [7:0] addr_hi_reg;
  logic load;
  logic [AW-1:0] load_addr;
  logic arr_wr;
  logic fifo_flush;
  sepr_byte_if #(.W(8)) arr_if ();
  sepr_byte_if #(.W(8)) fifo_if ();
  logic take_byte;
  // ****************
  // protocol state machine
  // ****************
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state_reg <= sepr_pkg::ST_IDLE;
      master_not_acknowledge_reg <= 1'b0;
      addr_hi_reg <= 8'h00;
    end else if (start_det) begin
      state_reg <= sepr_pkg::ST_DEVADDR;
    end else if (stop_det) begin
      state_reg <= sepr_pkg::ST_IDLE;
    end else begin
      unique case (state_reg)
        sepr_pkg::ST_IDLE: begin
          state_reg <= sepr_pkg::ST_IDLE;
        end
        sepr_pkg::ST_DEVADDR: begin
          if (byte_done) begin
            if (!addr_match(rx_byte, strap_reg) || o_busy) begin
              state_reg <= sepr_pkg::ST_IDLE;
            end else if (rx_byte[0] == sepr_pkg::RW_READ) begin
              state_reg <= sepr_pkg::ST_RDATA;
              master_not_acknowledge_reg <= 1'b0;
            end else begin
              state_reg <= sepr_pkg::ST_ADDR_HI;
            end
          end
        end
        sepr_pkg::ST_ADDR_HI: begin
          if (byte_done) begin
            addr_hi_reg <= rx_byte;
            state_reg <= sepr_pkg::ST_ADDR_LO;
          end
        end
        sepr_pkg::ST_ADDR_LO: begin
          if (byte_done) begin
            state_reg <= sepr_pkg::ST_WDATA;
          end
        end
        sepr_pkg::ST_WDATA: begin
          state_reg <= sepr_pkg::ST_WDATA;
        end
        sepr_pkg::ST_RDATA: begin
          // master sample of the ack slot decides continuation
          if (scl_rise && ack_slot) begin
            master_not_acknowledge_reg <= sda_s;
          end
          if (ack_close && master_not_acknowledge_reg) begin
            state_reg <= sepr_pkg::ST_IDLE;
          end
        end
        default: begin
          state_reg <= sepr_pkg::ST_IDLE;
        end
      endcase
    end
  end
  // counter load: drop msb, page 9 bits plus offset 6 bits
  assign load = (state_reg == sepr_pkg::ST_ADDR_LO) && byte_done && !start_det && !stop_det;
  assign load_addr = load ? {addr_hi_reg[AW-9:0], rx_byte} : cnt_reg;
  assign arr_wr = (state_reg == sepr_pkg::ST_WDATA) && byte_done && !start_det && !stop_det;
  assign fifo_flush = load || arr_wr || start_det;
  // byte transmitted to the master: counter moves on, top wraps to zero
  assign take_byte = (state_reg == sepr_pkg::ST_RDATA) && byte_done;
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cnt_reg <= sepr_pkg::ADDR_ZERO;
    end else if (load) begin
      cnt_reg <= load_addr;
    end else if (take_byte || arr_wr) begin
      cnt_reg <= cnt_reg + 1'b1;
    end
  end
  // write data byte advances the counter without an array write, with a write cycle after STOP
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      wr_pending_reg <= 1'b0;
      wcyc_reg <= '0;
    end else begin
      if (arr_wr) begin
        wr_pending_reg <= 1'b1;
      end else if (stop_det || start_det) begin
        wr_pending_reg <= 1'b0;
      end
      if (stop_det && wr_pending_reg) begin
        wcyc_reg <= ($clog2(WRITE_CYCLE_CYC+1))'(WRITE_CYCLE_CYC);
      end else if (wcyc_reg != '0) begin
        wcyc_reg <= wcyc_reg - 1'b1;
      end
    end
  end
  // array with prefetch, restarted at the counter after a load, a written byte or a start
  sepr_array #(.AW(AW)) u_array (
    .i_mclk(i_mclk),
    .i_rst_b(i_rst_b),
    .i_load(fifo_flush),
    .i_load_addr(arr_wr ? cnt_reg + 1'b1 : load_addr),
    .i_wr(1'b0),
    .i_wr_addr(cnt_reg),
    .i_wr_data(rx_byte),
    .out_if(arr_if)
  );
  sepr_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
    .i_mclk(i_mclk),
    .i_rst_b(i_rst_b),
    .i_flush(fifo_flush),
    .in_if(arr_if),
    .out_if(fifo_if)
  );
  // fifo head is popped when loaded into the transmit shifter
  logic load_tx;
  assign load_tx = ack_close && (state_reg == sepr_pkg::ST_RDATA)
                   && !master_not_acknowledge_reg && fifo_if.valid;
  assign fifo_if.ready = load_tx;
  // ****************
  // sda driver, changes on falling scl
  // ****************
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      drive_ack_reg <= 1'b0;
      drive_data_reg <= 1'b0;
      tx_reg <= 8'hff;
    end else if (start_det || stop_det) begin
      drive_ack_reg <= 1'b0;
      drive_data_reg <= 1'b0;
    end else if (ack_open) begin
      // data released for the master's answer; own bytes acked
      drive_data_reg <= 1'b0;
      drive_ack_reg <= ack_due;
    end else if (ack_close) begin
      drive_ack_reg <= 1'b0;
      drive_data_reg <= load_tx;
      if (load_tx) begin
        tx_reg <= fifo_if.data; // msb goes out now
      end
    end else if (scl_fall && drive_data_reg) begin
      tx_reg <= {tx_reg[6:0], 1'b1};
    end
  end
  // open drain: pull low only for ack or a zero data bit
  assign o_sda = 1'b0;
  assign o_sda_oe_b = !(drive_ack_reg || (drive_data_reg && !tx_reg[7]));
endmodule
`default_nettype wire

//--- verilog/sepr_pkg.sv
// Purpose: shared constants for the serial eeprom read path
// Assumes: one system clock samples the two-wire bus pins
// Notes: memory geometry, slave address pattern and timing counts
package sepr_pkg;
  // ****************
  // geometry
  // ****************
  localparam int ADDR_W = 15;
  localparam int DEPTH = 32768;
  localparam int PAGE_W = 9;
  localparam int OFFS_W = 6;
  localparam logic [7:0] ERASED_BYTE = 8'hff;
  localparam logic [14:0] ADDR_TOP = 15'h7fff;
  localparam logic [14:0] ADDR_ZERO = 15'h0000;
  // ****************
  // slave address byte
  // ****************
  localparam logic [3:0] SLAVE_PATTERN = 4'ha;
  localparam logic RW_READ = 1'b1;
  localparam logic [3:0] BIT_LAST = 4'h7;
  localparam logic [3:0] BIT_ACK = 4'h8;
  // ****************
  // timing
  // ****************
  localparam int CLK_MHZ = 50;
  localparam int WRITE_CYCLE_US = 5000;
  localparam int WRITE_CYCLE_CYC = WRITE_CYCLE_US * CLK_MHZ;
  // ****************
  // protocol states
  // ****************
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_DEVADDR = 3'b001,
    ST_ADDR_HI = 3'b010,
    ST_ADDR_LO = 3'b011,
    ST_WDATA = 3'b100,
    ST_RDATA = 3'b101
  } sepr_state_t;
endpackage

//--- verilog/sepr_byte_if.sv
// Purpose: byte stream carrier between memory fetch and bus shifter
// Assumes: both ends on i_mclk
// Notes: valid/ready handshake, data stands while valid
`timescale 1ns/10ps
`default_nettype none
interface sepr_byte_if #(parameter int W = 8);
  logic valid;
  logic ready;
  logic [W-1:0] data;
  // ****************
  // ends
  // ****************
  modport src (output valid, output data, input ready);
  modport dst (input valid, input data, output ready);
endinterface
`default_nettype wire

//--- verilog/sepr_fifo.sv
// Purpose: read-data FIFO between array fetch and the bus shifter
// Assumes: single clock, power of two depth
// Notes: full and empty are exact; ready in reflects free room
`timescale 1ns/10ps
`default_nettype none
module sepr_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic i_mclk,
  input wire logic i_rst_b,
  input wire logic i_flush,
  sepr_byte_if.dst in_if,
  sepr_byte_if.src out_if
);
  localparam int AW = $clog2(DEPTH);
  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH != $bits(in_if.data)) begin
      $error("sepr_fifo: bad parameters");
    end
  end
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr_reg;
  logic [AW:0] rd_ptr_reg;
  logic full;
  logic empty;
  logic push;
  logic pop;
  // ****************
  // flags and handshakes
  // ****************
  assign full = (wr_ptr_reg[AW] != rd_ptr_reg[AW]) && (wr_ptr_reg[AW-1:0] == rd_ptr_reg[AW-1:0]);
  assign empty = wr_ptr_reg == rd_ptr_reg;
  assign in_if.ready = !full;
  assign out_if.valid = !empty;
  assign out_if.data = mem[rd_ptr_reg[AW-1:0]];
  assign push = in_if.valid && !full;
  assign pop = out_if.ready && !empty;
  // storage write
  always_ff @(posedge i_mclk) begin
    if (push) begin
      mem[wr_ptr_reg[AW-1:0]] <= in_if.data;
    end
  end
  // pointers, flush empties the queue
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
    end else if (i_flush) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

//--- verilog/sepr_array.sv
// Purpose: byte array with prefetching read port feeding a stream
// Assumes: single clock; write port held idle by the protocol engine (i_wr tied low)
// Notes: array starts erased; fetch address follows the counter
`timescale 1ns/10ps
`default_nettype none
module sepr_array #(
  parameter int AW = sepr_pkg::ADDR_W
) (
  input wire logic i_mclk,
  input wire logic i_rst_b,
  input wire logic i_load,
  input wire logic [AW-1:0] i_load_addr,
  input wire logic i_wr,
  input wire logic [AW-1:0] i_wr_addr,
  input wire logic [7:0] i_wr_data,
  sepr_byte_if.src out_if
);
  logic [7:0] mem [2**AW];
  logic [AW-1:0] fetch_reg;
  logic [7:0] data_reg;
  logic valid_reg;
  // erased delivery contents
  initial begin
    for (int i = 0; i < 2**AW; i++) begin
      mem[i] = sepr_pkg::ERASED_BYTE;
    end
  end
  assign out_if.valid = valid_reg;
  assign out_if.data = data_reg;
  // array write
  always_ff @(posedge i_mclk) begin
    if (i_wr) begin
      mem[i_wr_addr] <= i_wr_data;
    end
  end
  // prefetch, address wraps naturally at the top
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      fetch_reg <= '0;
      valid_reg <= 1'b0;
      data_reg <= 8'h00;
    end else if (i_load || i_wr) begin
      fetch_reg <= i_load_addr;
      valid_reg <= 1'b0;
    end else if (!valid_reg || out_if.ready) begin
      data_reg <= mem[fetch_reg];
      fetch_reg <= fetch_reg + 1'b1;
      valid_reg <= 1'b1;
    end
  end
endmodule
`default_nettype wire

//--- dv/sepr_i2c_master.sv
// Purpose: bus master model driving the two-wire pins
// Assumes: SDA pulled up, 160 ns SCL period
// Notes: each byte result is posted on event got
`timescale 1ns/10ps
`default_nettype none
module sepr_i2c_master (
  output logic o_scl,
  output logic o_sda,
  input wire logic i_sda
);
  logic [7:0] rx;
  event got;
  initial begin
    o_scl = 1'b1;
    o_sda = 1'b1;
  end
  // ****************
  // bit and frame tasks
  // ****************
  task automatic wbit(input logic b);
    o_scl = 1'b0;
    #50 o_sda = b;
    #50 o_scl = 1'b1;
    #60;
  endtask
  task automatic rbit(output logic b);
    o_scl = 1'b0;
    o_sda = 1'b1;
    #100 o_scl = 1'b1;
    #40 b = i_sda;
    #20;
  endtask
  // start or repeated start after the address bytes
  task automatic start();
    o_scl = 1'b0;
    #100 o_sda = 1'b1;
    #50 o_scl = 1'b1;
    #40 o_sda = 1'b0;
    #40;
  endtask
  task automatic stop();
    o_scl = 1'b0;
    #100 o_sda = 1'b0;
    #50 o_scl = 1'b1;
    #40 o_sda = 1'b1;
    #60;
  endtask
  task automatic wbyte(input logic [7:0] v);
    logic a;
    for (int i = 7; i >= 0; i--) wbit(v[i]);
    rbit(a);
    rx = {7'h00, a};
    -> got;
  endtask
  // last byte left unacknowledged before stop
  task automatic rbyte(input logic last);
    logic [7:0] v;
    for (int i = 7; i >= 0; i--) rbit(v[i]);
    rx = v;
    -> got;
    wbit(last);
  endtask
endmodule
`default_nettype wire

//--- dv/sepr_top_props.sv
// Purpose: bus-level checks of the eeprom read path
// Assumes: pins change well away from i_mclk edges
// Notes: array content is erased so only acks pull SDA
`timescale 1ns/10ps
`default_nettype none
module sepr_top_props #(
  parameter int WRITE_CYCLE_CYC = 50
) (
  input wire logic i_mclk,
  input wire logic i_rst_b,
  input wire logic i_scl,
  input wire logic i_sda,
  input wire logic o_sda,
  input wire logic o_sda_oe_b,
  input wire logic i_device_select_strap_hi,
  input wire logic i_device_select_strap_mid,
  input wire logic i_device_select_strap_lo,
  input wire logic o_busy
);
  logic q_scl, q_sda, in_frame, first_byte;
  logic [3:0] bit_cnt, since_fall;
  logic [7:0] sh;
  int busy_cnt;
  wire rise = i_scl & ~q_scl;
  wire fall = ~i_scl & q_scl;
  wire start = i_scl & q_scl & q_sda & ~i_sda;
  wire stop = i_scl & q_scl & ~q_sda & i_sda;
  wire [6:0] match = {sepr_pkg::SLAVE_PATTERN, i_device_select_strap_hi,
    i_device_select_strap_mid, i_device_select_strap_lo};
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_rst_b);
  // ****************
  // bus tracking
  // ****************
  // pin history and cycle counters
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      q_scl <= 1'b1;
      q_sda <= 1'b1;
      since_fall <= 4'hf;
      busy_cnt <= 0;
    end else begin
      q_scl <= i_scl;
      q_sda <= i_sda;
      since_fall <= fall ? 4'h0 : (since_fall == 4'hf ? since_fall : since_fall + 4'h1);
      busy_cnt <= o_busy ? busy_cnt + 1 : 0;
    end
  end
  // frame and bit position
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      in_frame <= 1'b0;
      first_byte <= 1'b0;
      bit_cnt <= 4'h0;
      sh <= 8'h00;
    end else if (start) begin
      in_frame <= 1'b1;
      first_byte <= 1'b1;
      bit_cnt <= 4'h0;
    end else if (stop) begin
      in_frame <= 1'b0;
    end else if (rise) begin
      bit_cnt <= (bit_cnt == 4'h8) ? 4'h0 : bit_cnt + 4'h1;
      sh <= {sh[6:0], i_sda};
      if (bit_cnt == 4'h8) first_byte <= 1'b0;
    end
  end
  // ****************
  // properties
  // ****************
  sequence ack_hold;
    (!o_sda_oe_b) [*7];
  endsequence
  sequence addr_seen;
    fall && in_frame && first_byte && bit_cnt == 4'h8 && sh[7:1] == match;
  endsequence
  a_sda_value_low: assert property (o_sda == 1'b0) else $error("sda value not low");
  a_reset_released: assert property ($rose(i_rst_b) |-> o_sda_oe_b && !o_busy)
    else $error("bus held after reset");
  a_idle_released: assert property (!in_frame |-> o_sda_oe_b)
    else $error("sda pulled outside frame");
  a_ack_slot_only: assert property ($fell(o_sda_oe_b) |-> bit_cnt == 4'h8)
    else $error("pull outside ack slot");
  a_ack_stands: assert property ($fell(o_sda_oe_b) |-> ack_hold)
    else $error("ack too short");
  a_addr_match: assert property ($fell(o_sda_oe_b) && first_byte |-> sh[7:1] == match)
    else $error("foreign address acked");
  a_read_ack: assert property (addr_seen and !o_busy |-> ##[1:6] !o_sda_oe_b)
    else $error("own address not acked");
  a_busy_quiet: assert property (o_busy |-> o_sda_oe_b)
    else $error("ack during write cycle");
  a_change_after_fall: assert property ($changed(o_sda_oe_b) |-> since_fall <= 4'h6)
    else $error("sda change not after scl fall");
  a_busy_length: assert property ($fell(o_busy) |->
    busy_cnt >= WRITE_CYCLE_CYC - 2 && busy_cnt <= WRITE_CYCLE_CYC + 2)
    else $error("write cycle length wrong");
endmodule
bind sepr_top sepr_top_props #(.WRITE_CYCLE_CYC(WRITE_CYCLE_CYC)) u_props (
  .i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_scl(i_scl), .i_sda(i_sda), .o_sda(o_sda),
  .o_sda_oe_b(o_sda_oe_b), .i_device_select_strap_hi(i_device_select_strap_hi),
  .i_device_select_strap_mid(i_device_select_strap_mid),
  .i_device_select_strap_lo(i_device_select_strap_lo), .o_busy(o_busy));
`default_nettype wire

//--- dv/test_serial_eeprom_read_path.sv
// Purpose: self-checking bench for the eeprom read path
// Assumes: master model on the pins, wired-and SDA with pull-up
// Notes: expected bytes and acks queued, compared as they arrive
`timescale 1ns/10ps
`default_nettype none
module test_serial_eeprom_read_path;
  logic i_mclk, i_rst_b, o_sda, sda_oe_b, busy, scl, m_sda;
  logic [2:0] strap;
  logic [7:0] v;
  logic [7:0] exp_q[$];
  int failures, cmp_count, seed, k;
  // open drain wire with pull-up
  wire sda = m_sda & (sda_oe_b | o_sda);
  sepr_i2c_master u_m (.o_scl(scl), .o_sda(m_sda), .i_sda(sda));
  sepr_top #(.WRITE_CYCLE_CYC(200), .FIFO_DEPTH(16)) dut_u (
    .i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_scl(scl), .i_sda(sda), .o_sda(o_sda),
    .o_sda_oe_b(sda_oe_b), .i_device_select_strap_hi(strap[2]),
    .i_device_select_strap_mid(strap[1]), .i_device_select_strap_lo(strap[0]),
    .o_busy(busy));
  initial begin
    i_mclk = 1'b0;
    forever #10 i_mclk = ~i_mclk;
  end
  // ****************
  // checking and closing
  // ****************
  task automatic chk(input logic [7:0] seen, input logic [7:0] want);
    cmp_count++;
    if (seen !== want) begin
      failures++;
      $display("mismatch at %0t: got %h want %h", $time, seen, want);
    end
  endtask
  task automatic end_of_test();
    $display("failures %0d comparisons %0d", failures, cmp_count);
    if (failures == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // oldest note against each result
  always @(u_m.got) begin
    if (exp_q.size() == 0) begin
      failures++;
      $display("mismatch at %0t: unexpected result", $time);
    end else chk(u_m.rx, exp_q.pop_front());
  end
  initial begin
    repeat (50000) @(posedge i_mclk);
    failures++;
    $display("mismatch at %0t: run too long", $time);
    end_of_test();
  end
  // ****************
  // helpers
  // ****************
  task automatic do_reset();
    @(posedge i_mclk) #1 i_rst_b = 1'b0;
    strap = 3'($random(seed));
    repeat (3) @(posedge i_mclk);
    #1 i_rst_b = 1'b1;
    repeat (4) @(posedge i_mclk);
    #1;
  endtask
  task automatic put(input logic [7:0] ack, input logic [7:0] b);
    exp_q.push_back(ack);
    u_m.wbyte(b);
  endtask
  task automatic addr(input logic rw);
    put(8'h00, {sepr_pkg::SLAVE_PATTERN, strap, rw});
  endtask
  task automatic rd(input int n);
    for (int i = 0; i < n; i++) begin
      exp_q.push_back(sepr_pkg::ERASED_BYTE);
      u_m.rbyte(i == n - 1);
    end
  endtask
  // ****************
  // scenarios
  // ****************
  initial begin
    failures = 0;
    cmp_count = 0;
    seed = 32'h33aa7288;
    i_rst_b = 1'b0;
    strap = 3'h0;
    do_reset();
    // read at the counter, three bytes
    u_m.start();
    addr(1'b1);
    rd(3);
    u_m.stop();
    // dummy write below the top with msb set, read across the wrap
    u_m.start();
    addr(1'b0);
    put(8'h00, 8'hff);
    put(8'h00, 8'hfe);
    u_m.start();
    addr(1'b1);
    rd(4);
    u_m.stop();
    // foreign addresses get no answer
    for (k = 0; k < 6; k++) begin
      v = 8'($random(seed));
      if (v[7:1] == {sepr_pkg::SLAVE_PATTERN, strap}) v[4] = ~v[4];
      u_m.start();
      put(8'h01, v);
      u_m.stop();
    end
    // own address without a start
    put(8'h01, {sepr_pkg::SLAVE_PATTERN, strap, 1'b1});
    u_m.stop();
    // a data byte starts a write cycle that refuses the address
    u_m.start();
    addr(1'b0);
    put(8'h00, 8'h12);
    put(8'h00, 8'h34);
    put(8'h00, v);
    u_m.stop();
    u_m.start();
    put(8'h01, {sepr_pkg::SLAVE_PATTERN, strap, 1'b1});
    u_m.stop();
    for (k = 0; k < 400 && busy !== 1'b0; k++) @(posedge i_mclk);
    #1;
    if (busy !== 1'b0) begin
      failures++;
      $display("mismatch at %0t: write cycle never ends", $time);
      end_of_test();
    end
    u_m.start();
    addr(1'b1);
    rd(2);
    u_m.stop();
    // reset in mid-run with new straps
    do_reset();
    u_m.start();
    addr(1'b1);
    rd(1);
    u_m.stop();
    repeat (10) @(posedge i_mclk);
    end_of_test();
  end
endmodule
`default_nettype wire
